// [hbr_pkg.sv]
// hbr_pkg: shared constants and carrier types of the hid-report to i2c bridge
// assumes a single 100 MHz clock domain and a usb core that decodes tokens
// What this block and its host must do
// RQ1: hid port number is highest external plus one
// RQ2: no interrupt out; output reports via control
// RQ3: decode get report and set report setups
// RQ4: idle and protocol class requests are stalled
// RQ5: reports carry no report id byte
// RQ6: output report: opcode, address, length, data
// RQ7: opcode 1 read, 2 write+stop, 3 write nostop
// RQ8: report length must equal data stage bytes
// RQ9: status stage acks valid, stalls invalid request
// RQ10: too few data bytes stalls status stage
// RQ11: too many data bytes stalls data stage
// RQ12: byte counts stop at setup length; excess bytes discarded, stalled
// RQ13: host keeps start address plus length in range
// RQ14: zero opcode output report is stalled
// RQ15: i2c master stretches, 400 kHz or 100 kHz
// RQ16: on suspend writes finish, reads may abort
// RQ17: refuse l1 sleep while i2c is busy
// RQ18: host avoids suspending during i2c transfer
// RQ19: feature report returns fixed two byte id
// RQ20: input report: status, length, then read data
// RQ21: status 0 ok,1 timeout,2 addr nak,3 data nak
// RQ22: interrupt in naks until i2c transfer completes
// RQ23: timeout expiry reports status one
package hbr_pkg;
  // clock and i2c timing
  localparam int unsigned CLK_HZ     = 100_000_000;   // core clock rate
  localparam int unsigned I2C_FAST_HZ = 400_000;      // default bus rate
  localparam int unsigned I2C_STD_HZ  = 100_000;      // slow bus rate
  localparam int unsigned Q_FAST_CYC = (CLK_HZ + 4*I2C_FAST_HZ - 1) / (4*I2C_FAST_HZ);
  localparam int unsigned Q_STD_CYC  = (CLK_HZ + 4*I2C_STD_HZ - 1) / (4*I2C_STD_HZ);
  localparam int unsigned TMO_MS     = 35;            // transfer timeout
  localparam int unsigned TMO_CYC    = TMO_MS * (CLK_HZ / 1000);
  // setup request codes
  localparam logic [7:0]  RT_GET     = 8'hA1;         // class, interface, in
  localparam logic [7:0]  RT_SET     = 8'h21;         // class, interface, out
  localparam logic [7:0]  RQ_GET_REP = 8'h01;         // get report
  localparam logic [7:0]  RQ_SET_REP = 8'h09;         // set report
  localparam logic [15:0] WV_INPUT   = 16'h0100;      // input report
  localparam logic [15:0] WV_OUTPUT  = 16'h0200;      // output report
  localparam logic [15:0] WV_FEATURE = 16'h0300;      // feature report
  localparam logic [15:0] WIDX_HID   = 16'h0000;      // interface index
  // output report layout
  localparam logic [15:0] OUT_HDR    = 16'h0004;      // opcode, addr, len lo/hi
  localparam logic [15:0] POS_OP     = 16'h0000;
  localparam logic [15:0] POS_ADDR   = 16'h0001;
  localparam logic [15:0] POS_LLO    = 16'h0002;
  localparam logic [15:0] POS_LHI    = 16'h0003;
  localparam logic [15:0] IN_HDR     = 16'h0003;      // status, len lo/hi
  localparam logic [7:0]  OP_NONE    = 8'h00;
  localparam logic [7:0]  OP_READ    = 8'h01;
  localparam logic [7:0]  OP_WR_STOP = 8'h02;
  localparam logic [7:0]  OP_WR_HOLD = 8'h03;
  // input report status codes
  localparam logic [7:0]  ST_OK      = 8'h00;
  localparam logic [7:0]  ST_TMO     = 8'h01;
  localparam logic [7:0]  ST_ANAK    = 8'h02;
  localparam logic [7:0]  ST_DNAK    = 8'h03;
  localparam int unsigned FEAT_LEN   = 2;             // feature report bytes

  // setup packet fields
  typedef struct packed {
    logic [7:0]  req_type;                            // request type byte
    logic [7:0]  request;                             // request code
    logic [15:0] value;                               // report type and id
    logic [15:0] index;                               // interface
    logic [15:0] length;                              // data stage length
  } hbr_setup_t;

  // open-drain i2c line pair
  typedef struct packed {
    logic scl;                                        // clock line
    logic sda;                                        // data line
  } hbr_i2c_t;

  // i2c engine states
  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_START = 3'b001,
    I2C_BIT   = 3'b010,
    I2C_STOP  = 3'b011
  } hbr_i2c_st_t;
endpackage : hbr_pkg

// [hbr_top.sv]
// hbr_top: hid report engine plus i2c master behind the hub's internal port
// assumes a usb core that decodes setup, data and status stages and tokens
`timescale 1ns/1ps
module hbr_top #(
  parameter int unsigned NUM_EXT_PORTS = 4,               // exposed downstream ports
  parameter int unsigned MAX_LEN       = 64,              // i2c data buffer bytes
  parameter int unsigned TMO_LIMIT     = hbr_pkg::TMO_CYC, // timeout in cycles
  parameter logic [15:0] FEAT_ID       = 16'h5AA5         // arbitrary id value
) (
  input  wire logic               clk_i,          // 100 MHz clock
  input  wire logic               rst_b_i,        // sync reset, active low
  input  wire logic               ce_i,           // clock enable
  input  wire hbr_pkg::hbr_setup_t setup_i,       // setup packet
  input  wire logic               setup_vld_i,    // setup received pulse
  input  wire logic [7:0]         out_byte_i,     // control out data byte
  input  wire logic               out_vld_i,      // control out byte pulse
  input  wire logic               status_req_i,   // status stage of set report
  input  wire logic               int_in_req_i,   // interrupt in token
  input  wire logic               suspend_i,      // hub in l2 suspend
  input  wire logic               l1_req_i,       // l1 sleep request
  input  wire logic               slow_sel_i,     // select 100 kHz bus
  input  wire hbr_pkg::hbr_i2c_t   i2c_i,          // i2c line levels
  output hbr_pkg::hbr_i2c_t        i2c_o,          // i2c drive value, always low
  output hbr_pkg::hbr_i2c_t        i2c_oe_o,       // i2c drive enables
  output logic [7:0]              port_num_o,     // hid port number
  output logic                    setup_stall_o,  // setup refused pulse
  output logic                    data_stall_o,   // data stage stall pulse
  output logic                    status_ack_o,   // zero length ack pulse
  output logic                    status_stall_o, // status stage stall pulse
  output logic                    in_nak_o,       // in request nak pulse
  output logic [7:0]              in_byte_o,      // in data byte
  output logic                    in_vld_o,       // in byte valid
  output logic                    in_last_o,      // last in byte
  output logic                    l1_ack_o,       // l1 accepted pulse
  output logic                    l1_reject_o,    // l1 refused pulse
  output logic                    suspended_o     // hid function suspended
);
  import hbr_pkg::*;

  localparam int AW = $clog2(MAX_LEN);            // buffer index width

  hbr_i2c_t    i2c_m_q, i2c_s_q;                  // pin synchroniser
  logic [7:0]  mem_q [MAX_LEN];                   // write and read data
  logic        col_q;                             // collecting output report
  logic [15:0] wlen_q;                            // setup length
  logic [15:0] cnt_q;                             // data stage byte count
  logic [7:0]  op_q, addr_q;                      // command header
  logic [15:0] len_q;                             // i2c transfer length
  hbr_i2c_st_t st_q;                              // i2c engine state
  logic [1:0]  ph_q;                              // quarter phase
  logic [15:0] qcnt_q;                            // quarter counter
  logic [3:0]  bit_q;                             // bit 0..7, 8 is ack
  logic [7:0]  sh_q;                              // shift register
  logic        adr_ph_q;                          // address byte in flight
  logic [15:0] idx_q;                             // data byte index
  logic        busy_q;                            // i2c transfer running
  logic        rdy_q;                             // input report available
  logic [7:0]  stat_q;                            // transfer status code
  logic [31:0] tmo_q;                             // timeout counter
  logic        tx_q, tx_feat_q;                   // in stream state
  logic [15:0] tx_idx_q, tx_len_q;                // in stream position
  logic        start_w, valid_w, rd_w;            // decode helpers
  logic        get_in_w, get_feat_w, set_out_w;
  logic        q_tick_w, abort_w;
  logic [15:0] qlen_w;                            // quarter length
  logic [15:0] rpt_len_w;                         // full input report length

  // constant port number of the embedded function
  assign port_num_o = 8'(NUM_EXT_PORTS + 1);      // RQ1
  assign suspended_o = suspend_i;                 // RQ16

  // setup decode, no report id byte is ever expected
  assign get_in_w   = setup_i.req_type == RT_GET && setup_i.request == RQ_GET_REP
                      && setup_i.value == WV_INPUT && setup_i.index == WIDX_HID; // RQ3 RQ5
  assign get_feat_w = setup_i.req_type == RT_GET && setup_i.request == RQ_GET_REP
                      && setup_i.value == WV_FEATURE && setup_i.index == WIDX_HID; // RQ3
  assign set_out_w  = setup_i.req_type == RT_SET && setup_i.request == RQ_SET_REP
                      && setup_i.value == WV_OUTPUT && setup_i.index == WIDX_HID; // RQ3 RQ2

  // output report check at status stage
  assign rd_w    = op_q == OP_READ;
  assign valid_w = cnt_q == wlen_q && op_q != OP_NONE && op_q <= OP_WR_HOLD // RQ7 RQ8 RQ14
                   && (rd_w ? wlen_q == OUT_HDR
                            : {1'b0, wlen_q} == {1'b0, len_q} + {1'b0, OUT_HDR}) // RQ6 RQ10
                   && len_q <= 16'(MAX_LEN) && !busy_q;
  assign start_w = ce_i && col_q && status_req_i && valid_w;
  assign rpt_len_w = IN_HDR + (rd_w ? len_q : 16'h0000); // RQ20

  // two flops on the open-drain lines
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      i2c_m_q <= '1;
      i2c_s_q <= '1;
    end else if (ce_i) begin
      i2c_m_q <= i2c_i;
      i2c_s_q <= i2c_m_q;
    end
  end

  // setup and status stage answers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      setup_stall_o  <= 1'b0;
      status_ack_o   <= 1'b0;
      status_stall_o <= 1'b0;
      col_q          <= 1'b0;
      wlen_q         <= 16'h0000;
    end else if (ce_i) begin
      setup_stall_o  <= 1'b0;
      status_ack_o   <= 1'b0;
      status_stall_o <= 1'b0;
      if (setup_vld_i) begin
        // idle, protocol and any other request are refused
        setup_stall_o <= !(get_in_w || get_feat_w || set_out_w); // RQ4
        col_q         <= set_out_w;
        wlen_q        <= setup_i.length;
      end else if (col_q && status_req_i) begin
        // status tells only receipt and validity
        status_ack_o   <= valid_w;                // RQ9
        status_stall_o <= !valid_w;               // RQ9 RQ10 RQ14
        col_q          <= 1'b0;
      end
    end
  end

  // data stage collection of the output report
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_q        <= 16'h0000;
      op_q         <= OP_NONE;
      addr_q       <= 8'h00;
      len_q        <= 16'h0000;
      data_stall_o <= 1'b0;
    end else if (ce_i) begin
      data_stall_o <= 1'b0;
      if (setup_vld_i) begin
        cnt_q <= 16'h0000;
        // the header of a running transfer and its report stay intact
        if (set_out_w && !busy_q) op_q <= OP_NONE;
      end else if (col_q && out_vld_i) begin
        if (cnt_q >= wlen_q) begin
          data_stall_o <= 1'b1;                   // RQ11 RQ12
        end else begin
          cnt_q <= cnt_q + 16'h0001;              // RQ12
          if (!busy_q) begin
            case (cnt_q)
              POS_OP:   op_q         <= out_byte_i;
              POS_ADDR: addr_q       <= out_byte_i;
              POS_LLO:  len_q[7:0]   <= out_byte_i;
              POS_LHI:  len_q[15:8]  <= out_byte_i;
              default:  ;
            endcase
          end
        end
      end
    end
  end

  // quarter bit timing with clock stretching in the high phase
  assign qlen_w   = slow_sel_i ? 16'(Q_STD_CYC) : 16'(Q_FAST_CYC); // RQ15
  assign q_tick_w = qcnt_q == 16'h0000;
  // reads give up on suspend, writes run on; timeout ends anything
  assign abort_w  = busy_q && (tmo_q >= TMO_LIMIT - 1 || (suspend_i && rd_w)); // RQ16 RQ23

  // buffer writes from host bytes and from received i2c bytes
  always_ff @(posedge clk_i) begin
    if (ce_i && col_q && out_vld_i && cnt_q < wlen_q && cnt_q >= OUT_HDR
        && cnt_q - OUT_HDR < 16'(MAX_LEN) && !busy_q) begin
      mem_q[AW'(cnt_q - OUT_HDR)] <= out_byte_i;  // RQ6
    end else if (ce_i && st_q == I2C_BIT && ph_q == 2'd3 && q_tick_w && bit_q == 4'd8
                 && !adr_ph_q && rd_w) begin
      mem_q[AW'(idx_q)] <= sh_q;                  // RQ20
    end
  end

  // timeout counter over the whole transfer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tmo_q <= 32'h0000_0000;
    end else if (ce_i) begin
      tmo_q <= (busy_q && !start_w) ? tmo_q + 32'h0000_0001 : 32'h0000_0000; // RQ21
    end
  end

  // i2c master engine
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q     <= I2C_IDLE;
      ph_q     <= 2'd0;
      qcnt_q   <= 16'h0000;
      bit_q    <= 4'd0;
      sh_q     <= 8'h00;
      adr_ph_q <= 1'b0;
      idx_q    <= 16'h0000;
      busy_q   <= 1'b0;
      rdy_q    <= 1'b0;
      stat_q   <= ST_OK;
      i2c_oe_o <= '0;
    end else if (ce_i) begin
      if (start_w) begin
        // a new command retires the previous report
        st_q     <= I2C_START;
        ph_q     <= 2'd0;
        qcnt_q   <= qlen_w;
        busy_q   <= 1'b1;
        rdy_q    <= 1'b0;
        stat_q   <= ST_OK;
        adr_ph_q <= 1'b1;
        idx_q    <= 16'h0000;
        bit_q    <= 4'd0;
        sh_q     <= {addr_q[6:0], rd_w};          // RQ7
      end else if (abort_w) begin
        // release both lines and report the failure
        st_q     <= I2C_IDLE;
        i2c_oe_o <= '0;
        busy_q   <= 1'b0;
        rdy_q    <= 1'b1;
        stat_q   <= ST_TMO;                       // RQ21 RQ23
      end else if (st_q != I2C_IDLE) begin
        if (!q_tick_w) begin
          // high phases hold while a slave stretches the clock
          if (!(i2c_oe_o.scl == 1'b0 && i2c_s_q.scl == 1'b0 && ph_q >= 2'd2))
            qcnt_q <= qcnt_q - 16'h0001;          // RQ15
        end else begin
          qcnt_q <= qlen_w;
          ph_q   <= ph_q + 2'd1;
          case (st_q)
            I2C_START: begin
              // release sda, then scl, so a held bus gives a repeated start
              case (ph_q)
                2'd0:    i2c_oe_o.sda <= 1'b0;
                2'd1:    i2c_oe_o.scl <= 1'b0;
                2'd2:    i2c_oe_o.sda <= 1'b1;      // start: sda falls, scl high
                default: begin
                  i2c_oe_o.scl <= 1'b1;
                  st_q         <= I2C_BIT;
                end
              endcase
            end
            I2C_BIT: begin
              case (ph_q)
                2'd0: begin
                  i2c_oe_o.scl <= 1'b1;
                  if (bit_q == 4'd8)
                    i2c_oe_o.sda <= !adr_ph_q && rd_w && idx_q + 16'h0001 != len_q;
                  else
                    i2c_oe_o.sda <= (rd_w && !adr_ph_q) ? 1'b0 : !sh_q[7];
                end
                2'd1:    i2c_oe_o.scl <= 1'b0;
                2'd2: begin
                  if (bit_q != 4'd8) sh_q <= {sh_q[6:0], i2c_s_q.sda};
                  else if (i2c_s_q.sda && !(rd_w && !adr_ph_q))
                    stat_q <= adr_ph_q ? ST_ANAK : ST_DNAK; // RQ21
                end
                default: begin
                  i2c_oe_o.scl <= 1'b1;
                  bit_q        <= (bit_q == 4'd8) ? 4'd0 : bit_q + 4'd1;
                  if (bit_q == 4'd8) begin
                    adr_ph_q <= 1'b0;
                    if (!adr_ph_q) idx_q <= idx_q + 16'h0001;
                    sh_q <= mem_q[AW'(adr_ph_q ? idx_q : idx_q + 16'h0001)];
                    if (stat_q != ST_OK || (adr_ph_q ? len_q == 16'h0000
                                                     : idx_q + 16'h0001 == len_q))
                      st_q <= I2C_STOP;
                  end
                end
              endcase
            end
            I2C_STOP: begin
              case (ph_q)
                2'd0: begin
                  i2c_oe_o.scl <= 1'b1;
                  i2c_oe_o.sda <= !(op_q == OP_WR_HOLD && stat_q == ST_OK);
                end
                2'd1: begin
                  // a write without stop keeps scl held low, sda released
                  if (op_q == OP_WR_HOLD && stat_q == ST_OK) begin
                    st_q   <= I2C_IDLE;               // RQ7
                    busy_q <= 1'b0;
                    rdy_q  <= 1'b1;
                  end else begin
                    i2c_oe_o.scl <= 1'b0;
                  end
                end
                2'd2:    i2c_oe_o.sda <= 1'b0;
                default: begin
                  st_q   <= I2C_IDLE;
                  busy_q <= 1'b0;
                  rdy_q  <= 1'b1;                 // RQ22
                end
              endcase
            end
            default: st_q <= I2C_IDLE;
          endcase
        end
      end
    end
  end
  assign i2c_o = '0;                              // open drain drives low only

  // in stream: feature id or input report, naks while busy
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_q      <= 1'b0;
      tx_feat_q <= 1'b0;
      tx_idx_q  <= 16'h0000;
      tx_len_q  <= 16'h0000;
      in_nak_o  <= 1'b0;
      in_vld_o  <= 1'b0;
      in_last_o <= 1'b0;
      in_byte_o <= 8'h00;
    end else if (ce_i) begin
      in_nak_o <= 1'b0;
      if (!tx_q && setup_vld_i && get_feat_w) begin
        tx_q      <= setup_i.length != 16'h0000;  // RQ19
        tx_feat_q <= 1'b1;
        tx_idx_q  <= 16'h0000;
        tx_len_q  <= (setup_i.length < 16'(FEAT_LEN)) ? setup_i.length : 16'(FEAT_LEN);
      end else if (!tx_q && ((setup_vld_i && get_in_w) || int_in_req_i)) begin
        if (!rdy_q || busy_q) begin
          in_nak_o <= 1'b1;                       // RQ22
        end else begin
          // control reads are cut to the setup length
          tx_q      <= !(setup_vld_i && setup_i.length == 16'h0000);
          tx_feat_q <= 1'b0;
          tx_idx_q  <= 16'h0000;
          tx_len_q  <= (setup_vld_i && setup_i.length < rpt_len_w)
                       ? setup_i.length : rpt_len_w; // RQ20 RQ2
        end
      end else if (tx_q) begin
        tx_idx_q  <= tx_idx_q + 16'h0001;
        tx_q      <= tx_idx_q + 16'h0001 != tx_len_q;
      end
      in_vld_o  <= tx_q;
      in_last_o <= tx_q && tx_idx_q + 16'h0001 == tx_len_q;
      if (tx_feat_q)
        in_byte_o <= tx_idx_q[0] ? FEAT_ID[15:8] : FEAT_ID[7:0]; // RQ19
      else if (tx_idx_q == 16'h0000)
        in_byte_o <= stat_q;                      // RQ20 RQ21
      else if (tx_idx_q == 16'h0001)
        in_byte_o <= rd_w ? len_q[7:0] : 8'h00;
      else if (tx_idx_q == 16'h0002)
        in_byte_o <= rd_w ? len_q[15:8] : 8'h00;
      else
        in_byte_o <= mem_q[AW'(tx_idx_q - IN_HDR)];
    end
  end

  // l1 entry is refused during any transfer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      l1_ack_o    <= 1'b0;
      l1_reject_o <= 1'b0;
    end else if (ce_i) begin
      l1_ack_o    <= l1_req_i && !busy_q;
      l1_reject_o <= l1_req_i && busy_q;          // RQ17
    end
  end

  // checks
  sequence s_feat_setup;
    ce_i && setup_vld_i && get_feat_w && !tx_q && setup_i.length >= 16'h0002;
  endsequence
  sequence s_feat_bytes;
    ##1 ce_i ##1 (in_vld_o && in_byte_o == FEAT_ID[7:0])
    ##1 (in_vld_o && in_last_o && in_byte_o == FEAT_ID[15:8]);
  endsequence
  property p_port_num;
    @(posedge clk_i) disable iff (!rst_b_i) port_num_o == 8'(NUM_EXT_PORTS + 1);
  endproperty
  a_port_num: assert property (p_port_num) else $error("bad port number"); // RQ1
  property p_setup_stall;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && setup_vld_i && !(get_in_w || get_feat_w || set_out_w) |=> setup_stall_o;
  endproperty
  a_setup_stall: assert property (p_setup_stall) else $error("request not stalled"); // RQ4
  property p_op_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && col_q && status_req_i && op_q == OP_NONE |=> status_stall_o && !status_ack_o;
  endproperty
  a_op_zero: assert property (p_op_zero) else $error("zero opcode accepted"); // RQ14
  property p_extra_byte;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && col_q && out_vld_i && cnt_q >= wlen_q |=> data_stall_o && $stable(cnt_q);
  endproperty
  a_extra_byte: assert property (p_extra_byte) else $error("excess byte kept"); // RQ11
  property p_int_nak;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && int_in_req_i && !tx_q && busy_q && !setup_vld_i |=> in_nak_o && !in_vld_o;
  endproperty
  a_int_nak: assert property (p_int_nak) else $error("in served while busy"); // RQ22
  property p_l1_busy;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && l1_req_i && busy_q |=> l1_reject_o && !l1_ack_o;
  endproperty
  a_l1_busy: assert property (p_l1_busy) else $error("l1 taken while busy"); // RQ17
  property p_wr_survives;
    @(posedge clk_i) disable iff (!rst_b_i)
      ce_i && busy_q && suspend_i && !rd_w && tmo_q < 32'(TMO_LIMIT) - 2
      |=> busy_q || stat_q != ST_TMO;
  endproperty
  a_wr_survives: assert property (p_wr_survives) else $error("write cut by suspend"); // RQ16
  property p_status_code;
    @(posedge clk_i) disable iff (!rst_b_i) rdy_q |-> stat_q <= ST_DNAK;
  endproperty
  a_status_code: assert property (p_status_code) else $error("bad status code"); // RQ21
  property p_feat_id;
    @(posedge clk_i) disable iff (!rst_b_i) s_feat_setup |-> s_feat_bytes;
  endproperty
  a_feat_id: assert property (p_feat_id) else $error("feature id wrong"); // RQ19
endmodule : hbr_top

// [hbr_i2c_peer.sv]
// hbr_i2c_peer: pulled-up i2c wires and a slave that acks each byte
// assumes bridge enables that are high while they pull a line low
`timescale 1ns/1ps
module hbr_i2c_peer (
  input  wire logic             clk_i,    // core clock
  input  wire logic             ack_en_i, // slave acks when high
  input  wire hbr_pkg::hbr_i2c_t oe_i,    // bridge drive enables
  output hbr_pkg::hbr_i2c_t      line_o   // resolved line levels
);
  import hbr_pkg::*;
  logic [3:0] cnt_q = 4'h0; // bit slot since start
  hbr_i2c_t   prv_q = 2'h3; // lines one cycle earlier
  // wired-and with pull-ups; slave pulls sda in slot nine
  assign line_o.scl = ~oe_i.scl;
  assign line_o.sda = ~oe_i.sda & ~(ack_en_i & (cnt_q == 4'h9));
  // count scl falls, restart on a start condition
  always_ff @(posedge clk_i) begin
    prv_q <= line_o;
    if (line_o.scl & prv_q.sda & ~line_o.sda) cnt_q <= 4'h0;
    else if (prv_q.scl & ~line_o.scl) cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
  end
endmodule : hbr_i2c_peer

// [hbr_top_test.sv]
// hbr_top_test: hid requests in, replies checked against queued notes
// assumes hbr_top and the hbr_i2c_peer slave on its i2c pins
`timescale 1ns/1ps
module hbr_top_test;
  import hbr_pkg::*;
  logic       clk_i = 1'b0, rst_b_i = 1'b0, ack_en = 1'b1, slow = 1'b0;
  logic [4:0] req = 5'h00;    // setup, byte, status, int in, l1
  wire  [6:0] ev;             // reply pulses, setup stall first
  logic [7:0] out_byte_i = 8'h00, in_byte_o, port_num_o, d;
  logic       in_vld_o;       // in byte valid
  hbr_setup_t setup_i = '0;   // setup packet
  hbr_i2c_t   i2c_oe_o, line; // enables, line levels
  logic [7:0] q_ev[$], q_by[$];
  logic [7:0] bad[4] = '{8'h0A, 8'h0B, 8'h02, 8'h03}; // idle, protocol
  int         n_mismatch = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  hbr_top #(.TMO_LIMIT(30000)) u_dut (.clk_i, .rst_b_i, .ce_i(1'b1), .setup_i,
    .setup_vld_i(req[4]), .out_byte_i, .out_vld_i(req[3]), .status_req_i(req[2]),
    .int_in_req_i(req[1]), .l1_req_i(req[0]), .suspend_i(1'b0), .slow_sel_i(slow),
    .i2c_i(line), .i2c_o(), .i2c_oe_o, .port_num_o, .setup_stall_o(ev[6]),
    .data_stall_o(ev[5]), .status_ack_o(ev[4]), .status_stall_o(ev[3]),
    .in_nak_o(ev[2]), .in_byte_o, .in_vld_o, .in_last_o(), .l1_ack_o(ev[1]),
    .l1_reject_o(ev[0]), .suspended_o());
  hbr_i2c_peer u_peer (.clk_i, .ack_en_i(ack_en), .oe_i(i2c_oe_o), .line_o(line));
  // compare one reply with its note
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // one-cycle request pulse, launched just after an edge
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i); #1 req = m;
    @(posedge clk_i); #1 req = 5'h00;
  endtask : pulse
  // set report with its bytes; a data stall note skips the status stage
  task automatic rep(input logic [7:0] b[$], input logic [15:0] wl, input logic [7:0] e);
    q_ev.push_back(e);
    setup_i = '{RT_SET, RQ_SET_REP, WV_OUTPUT, WIDX_HID, wl};
    pulse(5'h10);
    foreach (b[i]) begin
      out_byte_i = b[i];
      pulse(5'h08);
    end
    if (e != 8'h20) pulse(5'h04);
  endtask : rep
  // get report setup of a given type and length
  task automatic get(input logic [15:0] v, input logic [15:0] n);
    setup_i = '{RT_GET, RQ_GET_REP, v, WIDX_HID, n};
    pulse(5'h10);
  endtask : get
  // transfer over once the enables rest 1000 cycles, beyond any slow quarter pair
  task automatic idle;
    int k;
    hbr_i2c_t p;
    k = 0;
    for (int t = 0; t < 40000 && k < 1000; t++) begin
      p = i2c_oe_o;
      @(negedge clk_i);
      k = (i2c_oe_o === p) ? k + 1 : 0;
    end
    if (k < 1000) n_mismatch++;
  endtask : idle
  task automatic summarize;
    n_mismatch += q_ev.size() + q_by.size();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // watcher: every reply takes the oldest note of its kind
  always @(negedge clk_i) begin
    if (|ev) chk(q_ev.pop_front(), {1'b0, ev});
    if (in_vld_o === 1'b1) chk(q_by.pop_front(), in_byte_o);
  end
  initial begin
    #1_000_000 n_mismatch++;
    summarize;
  end
  initial begin
    d = 8'($urandom(32'hD5EA));
    repeat (8) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk(8'h05, port_num_o);
    foreach (bad[i]) begin
      q_ev.push_back(8'h40);
      setup_i = '{bad[i][3] ? RT_SET : RT_GET, bad[i], 16'h0000, WIDX_HID, 16'h0000};
      pulse(5'h10);
    end
    q_by = {q_by, 8'hA5, 8'h5A};
    get(WV_FEATURE, 16'h0002);
    rep('{OP_WR_STOP, 8'h50, 8'h01, 8'h00, d}, 16'h0005, 8'h10);
    q_ev = {q_ev, 8'h04, 8'h01};
    pulse(5'h02);
    pulse(5'h01);
    idle;
    q_ev.push_back(8'h02);
    pulse(5'h01);
    q_by = {q_by, ST_OK, 8'h00, 8'h00};
    pulse(5'h02);
    ack_en = 1'b0;
    rep('{OP_WR_STOP, 8'h50, 8'h01, 8'h00, d}, 16'h0005, 8'h10);
    idle;
    ack_en = 1'b1;
    q_by = {q_by, ST_ANAK, 8'h00, 8'h00};
    pulse(5'h02);
    slow = 1'b1;
    rep('{OP_WR_HOLD, 8'h50, 8'h01, 8'h00, d}, 16'h0005, 8'h10);
    idle;
    slow = 1'b0;
    rep('{OP_READ, 8'h50, 8'h01, 8'h00}, 16'h0004, 8'h10);
    idle;
    q_by = {q_by, ST_OK, 8'h01, 8'h00, 8'hFF};
    get(WV_INPUT, 16'h0004);
    rep('{OP_NONE, 8'h50, 8'h00, 8'h00}, 16'h0004, 8'h08);
    rep('{OP_WR_STOP, 8'h50, 8'h01, 8'h00}, 16'h0005, 8'h08);
    rep('{OP_WR_STOP, 8'h50, 8'h01, 8'h00, d, d}, 16'h0005, 8'h20);
    repeat (20) @(posedge clk_i);
    summarize;
  end
endmodule : hbr_top_test
